// ===== verilog/adc_port_pkg.sv
// constants and types shared by the converter host port
//
// Function
// - unclipped mode passes full 15-bit adjusted result
// - offset field is two's-complement signed
// - offset kept, replaced by later write
// - select pins: 01 immediate, 10 deferred
// - immediate: output loads as busy rises
// - deferred: output loads at next start fall
// - data lines driven only when select, read low
// - busy low through conversion, rises at end
// - stored offset added to raw result
// - saturation clamps output to 0 .. 0x3fff
// - saturation: top bit flags out-of-range input
package adc_port_pkg;

	// ----------------------------------------------------------------
	// widths and limits
	// ----------------------------------------------------------------
	localparam int          DATA_W        = 15;           // data bus lines
	localparam int          OFFSET_W      = 12;           // offset field
	localparam int          FIFO_DEPTH    = 16;           // result buffer words
	localparam logic [15:0] CODE_MAX      = 16'h3fff;     // top nominal code
	localparam logic [11:0] OFFSET_RESET  = 12'h000;      // offset after reset
	localparam logic [14:0] RESULT_RESET  = 15'h0000;     // output after reset

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;                      // 125 MHz
	localparam int CONV_TIME_NS  = 300;                    // conversion time
	localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// select pin encodings {second, first}
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_IMMEDIATE = 2'h1;          // update at busy rise
	localparam logic [1:0] MODE_DEFERRED  = 2'h2;          // update at next start

	// conversion sequencer states, gray along the path
	typedef enum logic [1:0] {
		ST_IDLE    = 2'h0,
		ST_CONVERT = 2'h1,
		ST_PUSH    = 2'h3,
		ST_SETTLE  = 2'h2
	} conv_state_e;

	// one finished conversion word as it sits on the bus
	typedef struct packed {
		logic        overrange_bit;                        // top line
		logic [13:0] code;                                 // result code
	} result_s;

endpackage

// ===== verilog/adc_parallel_readout_offset.sv
// converter host port: conversion sequencing, offset, result buffer, bus
//
// ----------------------------------------------------------------------
// result buffer
// ----------------------------------------------------------------------
module result_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_nrst,
	// fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output      logic             o_in_ready,
	// drain side
	output      logic             o_out_valid,
	output      logic [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];                         // storage words
	logic [AW:0]      wr_ptr;                              // write pointer, wrap bit on top
	logic [AW:0]      rd_ptr;                              // read pointer, wrap bit on top
	wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	wire              empty = (wr_ptr == rd_ptr);
	wire              push  = i_in_valid && !full;
	wire              pop   = i_out_ready && !empty;

	assign o_in_ready  = !full;
	assign o_out_valid = !empty;
	assign o_out_data  = mem[rd_ptr[AW-1:0]];

	// pointers
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	// storage write
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= i_in_data;
		end
	end
endmodule

// ----------------------------------------------------------------------
// top level
// ----------------------------------------------------------------------
module adc_parallel_readout_offset #(
	parameter int CONV_CYCLES = adc_port_pkg::CONV_CYCLES,
	parameter int FIFO_DEPTH  = adc_port_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// conversion control pins
	input  wire logic        i_convert_start_n,
	output      logic        o_busy_n,
	// configuration pins
	input  wire logic [1:0]  i_mode_sel,
	input  wire logic        i_saturate_enable,
	// parallel bus pins
	input  wire logic        i_cs_n,
	input  wire logic        i_rd_n,
	input  wire logic        i_wr_n,
	input  wire logic [14:0] i_data,
	output      logic [14:0] o_data,
	output      logic        o_data_oe,
	// converter core
	input  wire logic [14:0] i_raw_approx_result,
	output      logic        o_sample_hold
);
	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [1:0]  start_sync;                               // start pin stages
	logic [1:0]  cs_sync;                                  // select stages
	logic [1:0]  rd_sync;                                  // read stages
	logic [1:0]  wr_sync;                                  // write stages
	logic [1:0]  sat_sync;                                 // saturation stages
	logic [1:0]  mode_a;                                   // select pins first stage
	logic [1:0]  mode_q;                                   // select pins second stage
	logic [14:0] din_a;                                    // data bus first stage
	logic [14:0] din_q;                                    // data bus second stage
	logic        start_d;                                  // start, one cycle older
	logic        wr_d;                                     // write, one cycle older

	// two flops per pin, then one delay stage for edge finding
	always_ff @(posedge i_clk) begin
		start_sync <= {start_sync[0], i_convert_start_n};
		cs_sync    <= {cs_sync[0], i_cs_n};
		rd_sync    <= {rd_sync[0], i_rd_n};
		wr_sync    <= {wr_sync[0], i_wr_n};
		sat_sync   <= {sat_sync[0], i_saturate_enable};
		mode_a     <= i_mode_sel;
		mode_q     <= mode_a;
		din_a      <= i_data;
		din_q      <= din_a;
		start_d    <= start_sync[1];
		wr_d       <= wr_sync[1];
	end

	// edge and level decode
	wire start_fall = start_d && !start_sync[1];           // new conversion
	wire wr_rise    = !wr_d && wr_sync[1];                 // end of write strobe
	wire cs_low     = !cs_sync[1];
	wire rd_low     = !rd_sync[1];
	wire sat_on     = sat_sync[1];
	wire mode_def   = (mode_q == adc_port_pkg::MODE_DEFERRED);
	// unused select patterns fall back to immediate update
	wire mode_imm   = !mode_def;

	// ------------------------------------------------------------------
	// offset register
	// ------------------------------------------------------------------
	logic [11:0] offset_adjust;                            // signed offset field
	wire         offset_wr = wr_rise && cs_low;

	// latched until the next write, reset only by i_nrst
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			offset_adjust <= adc_port_pkg::OFFSET_RESET;
		end else if (offset_wr) begin
			offset_adjust <= din_q[11:0];
		end
	end

	// ------------------------------------------------------------------
	// offset arithmetic
	// ------------------------------------------------------------------
	logic [14:0] raw_latched;                              // held sample of the core
	wire  [15:0] raw_ext = {raw_latched[14], raw_latched};
	wire  [15:0] off_ext = {{4{offset_adjust[11]}}, offset_adjust};
	wire  [15:0] sum     = raw_ext + off_ext;
	wire         sum_neg = sum[15];
	wire         sum_big = !sum_neg && (sum > adc_port_pkg::CODE_MAX);
	wire         raw_out = raw_ext[15] || (raw_ext > adc_port_pkg::CODE_MAX);
	wire  [13:0] saturate_enable_code = sum_neg ? 14'h0000 :
	                         sum_big ? 14'h3fff : sum[13:0];
	adc_port_pkg::result_s adj;                            // value to buffer

	// clamp with flag, or full two's complement pass-through
	assign adj = sat_on ? adc_port_pkg::result_s'({raw_out, saturate_enable_code})
	                    : adc_port_pkg::result_s'(sum[14:0]);

	// ------------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------------
	localparam int CW = $clog2(CONV_CYCLES + 1);
	adc_port_pkg::conv_state_e state;                      // current state
	adc_port_pkg::conv_state_e next_state;                 // next state
	logic [CW-1:0] conv_cnt;                               // cycles left in conversion
	logic          fifo_in_ready;                          // buffer can take a word
	wire           conv_done = (conv_cnt == CW'(1));
	wire           push      = (state == adc_port_pkg::ST_PUSH);

	// next state
	always_comb begin
		next_state = state;
		case (state)
			adc_port_pkg::ST_IDLE: begin
				if (start_fall) begin
					next_state = adc_port_pkg::ST_CONVERT;
				end
			end
			adc_port_pkg::ST_CONVERT: begin
				if (conv_done) begin
					next_state = adc_port_pkg::ST_PUSH;
				end
			end
			adc_port_pkg::ST_PUSH: begin
				// a full buffer stalls the conversion end
				if (fifo_in_ready) begin
					next_state = adc_port_pkg::ST_SETTLE;
				end
			end
			adc_port_pkg::ST_SETTLE: begin
				next_state = adc_port_pkg::ST_IDLE;
			end
			default: begin
				next_state = adc_port_pkg::ST_IDLE;
			end
		endcase
	end

	// state, counter, sample latch and busy
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			state       <= adc_port_pkg::ST_IDLE;
			conv_cnt    <= '0;
			raw_latched <= '0;
			o_busy_n    <= 1'b1;
		end else begin
			state <= next_state;
			if (state == adc_port_pkg::ST_IDLE && start_fall) begin
				conv_cnt <= CW'(CONV_CYCLES);
				o_busy_n <= 1'b0;
			end else if (conv_cnt != '0) begin
				conv_cnt <= conv_cnt - 1'b1;
			end
			if (state == adc_port_pkg::ST_CONVERT && conv_done) begin
				raw_latched <= i_raw_approx_result;
			end
			if (state == adc_port_pkg::ST_SETTLE) begin
				o_busy_n <= 1'b1;
			end
		end
	end

	assign o_sample_hold = (state == adc_port_pkg::ST_CONVERT);

	// ------------------------------------------------------------------
	// result buffer and output register
	// ------------------------------------------------------------------
	logic                  fifo_out_valid;                 // word waiting
	logic [14:0]           fifo_out_data;                  // oldest word
	logic [14:0]           out_reg;                        // output register
	// immediate pops as soon as a word lands, deferred on the start fall
	wire                   pop = fifo_out_valid && (mode_imm || start_fall);

	result_fifo #(
		.WIDTH (15),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_nrst      (i_nrst),
		.i_in_valid  (push),
		.i_in_data   (adj),
		.o_in_ready  (fifo_in_ready),
		.o_out_valid (fifo_out_valid),
		.o_out_data  (fifo_out_data),
		.i_out_ready (pop)
	);

	// output register load
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			out_reg <= adc_port_pkg::RESULT_RESET;
		end else if (pop) begin
			out_reg <= fifo_out_data;
		end
	end

	// ------------------------------------------------------------------
	// data bus drive
	// ------------------------------------------------------------------
	assign o_data    = out_reg;
	assign o_data_oe = cs_low && rd_low;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	// strobe pins as they stood two edges back, held against the drive
	a_bus_drive_gate: assert property (
		o_data_oe |-> !$past(i_rd_n, 2) && !$past(i_cs_n, 2)
	)
		else $error("data driven without select and read");
	a_bus_drive_on: assert property (
		!$past(i_rd_n, 2) && !$past(i_cs_n, 2) |-> o_data_oe
	)
		else $error("data not driven under select and read");
	a_hold_in_busy: assert property (o_sample_hold |-> !o_busy_n)
		else $error("sample held while not busy");
	a_busy_through_conv: assert property (
		$fell(o_busy_n) |-> !o_busy_n [*8] ##1 (!o_busy_n && state != adc_port_pkg::ST_IDLE)
	)
		else $error("busy rose early");
	a_busy_ends: assert property ($fell(o_busy_n) |-> ##[1:200] $rose(o_busy_n))
		else $error("busy stuck low");
	a_imm_update_time: assert property (
		mode_imm && pop |=> $rose(o_busy_n)
	)
		else $error("immediate load not at busy rise");
	a_defer_update_time: assert property (
		(mode_def && out_reg != $past(out_reg)) |-> $past(start_fall)
	)
		else $error("deferred load without start fall");
	a_offset_capture: assert property (offset_wr |=> offset_adjust == $past(din_q[11:0]))
		else $error("offset not captured");
	a_offset_hold: assert property (!offset_wr |=> $stable(offset_adjust))
		else $error("offset changed without write");
	a_clamp_low: assert property (sat_on && sum_neg |-> adj.code == 14'h0000)
		else $error("negative sum not clamped");
	a_clamp_high: assert property (sat_on && sum_big |-> adj.code == 14'h3fff)
		else $error("large sum not clamped");
	a_flag_overrange: assert property (sat_on |-> adj.overrange_bit == raw_out)
		else $error("overrange flag wrong");
	a_unclipped_pass: assert property (!sat_on |-> adj == sum[14:0])
		else $error("unclipped result altered");

	c_imm_conv:   cover property (mode_imm && pop ##1 o_busy_n);
	c_defer_conv: cover property (mode_def && start_fall && fifo_out_valid);
	c_offset_wr:  cover property (offset_wr && din_q[11]);
	c_unclip_neg: cover property (!sat_on && push && sum_neg);
endmodule

// ===== dv/host_model.sv
// host side model: offset writes, result reads and conversion starts
module host_model (
	// clock and device outputs
	input  wire logic        i_clk,
	input  wire logic        i_busy_n,
	input  wire logic        i_oe,
	input  wire logic [14:0] i_q,
	// pins driven toward the device
	output      logic        o_cs_n,
	output      logic        o_rd_n,
	output      logic        o_wr_n,
	output      logic        o_start_n,
	output      logic [14:0] o_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle levels at time zero
	initial begin
		{o_cs_n, o_rd_n, o_wr_n, o_start_n} = 4'hf;
		o_data = 15'h0000;
	end
	// offset write: data held well around the strobe rise
	task automatic bus_wr(input logic [11:0] off, input logic cs_n);
		@(posedge i_clk);
		o_cs_n <= cs_n;
		o_data <= {3'h0, off};
		o_wr_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		o_wr_n <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_cs_n <= 1'b1;
		o_data <= ~o_data; // released bus shows no stale value
		repeat (4) @(posedge i_clk);
	endtask
	// read cycle, sampled mid-cycle once the strobes are synced
	task automatic bus_rd(input logic cs_n, output logic oe, output logic [14:0] d);
		@(posedge i_clk);
		o_cs_n <= cs_n;
		o_rd_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		@(negedge i_clk);
		oe = i_oe;
		d = i_q;
		@(posedge i_clk);
		o_rd_n <= 1'b1;
		o_cs_n <= 1'b1;
		repeat (4) @(posedge i_clk);
	endtask
	// start pulse, then wait for busy to fall
	task automatic conv_start(output logic ok);
		int n;
		@(posedge i_clk);
		o_start_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		o_start_n <= 1'b1;
		for (n = 0; n < 10 && i_busy_n !== 1'b0; n++) @(negedge i_clk);
		ok = (i_busy_n === 1'b0);
	endtask
	// wait for busy to rise at conversion end
	task automatic conv_end(output logic ok);
		int n;
		for (n = 0; n < 200 && i_busy_n !== 1'b1; n++) @(negedge i_clk);
		ok = (i_busy_n === 1'b1);
	endtask
endmodule

// ===== dv/adc_parallel_readout_offset_tb_top.sv
// self-checking bench for the converter host port
module adc_parallel_readout_offset_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	localparam int          CONV    = 9;   // shortened conversion count
	localparam logic [11:0] offs[5] = '{12'he00, 12'h000, 12'h400, 12'hae2, 12'h51e};
	localparam logic [14:0] raws[6] = '{15'h7ae2, 15'h7c00, 15'h0000, 15'h0200,
		15'h3bff, 15'h3fff};
	logic        i_clk;
	logic        i_nrst;
	logic [1:0]  mode_sel;
	logic        sat;
	logic [14:0] raw;
	logic        cs_n, rd_n, wr_n, start_n, busy_n, dut_oe, oe, ok;
	logic [14:0] host_data;
	logic [14:0] q;
	logic [14:0] d;
	logic [14:0] held;
	logic [11:0] off;
	logic        sh;
	logic [31:0] seed        = 32'h6553;
	int          error_cnt   = 0;
	int          comparisons = 0;
	// ---------------------------------------------------------------
	// design and host model
	// ---------------------------------------------------------------
	adc_parallel_readout_offset #(.CONV_CYCLES(CONV), .FIFO_DEPTH(16)) dut (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_convert_start_n(start_n), .o_busy_n(busy_n),
		.i_mode_sel(mode_sel), .i_saturate_enable(sat), .i_cs_n(cs_n), .i_rd_n(rd_n),
		.i_wr_n(wr_n), .i_data(host_data), .o_data(q), .o_data_oe(dut_oe),
		.i_raw_approx_result(raw), .o_sample_hold(sh));
	host_model h (.i_clk(i_clk), .i_busy_n(busy_n), .i_oe(dut_oe), .i_q(q), .o_cs_n(cs_n),
		.o_rd_n(rd_n), .o_wr_n(wr_n), .o_start_n(start_n), .o_data(host_data));
	// 8 ns clock
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// expected output word: sum, then clamp and flag when saturating
	function automatic logic [14:0] exp_out(input logic [14:0] r, input logic [11:0] o,
		input logic s);
		logic [15:0] sum;
		logic [13:0] c;
		sum = {r[14], r} + {{4{o[11]}}, o};
		c = sum[15] ? 14'h0000 : (sum > 16'h3fff ? 14'h3fff : sum[13:0]);
		return s ? {r[14], c} : sum[14:0];
	endfunction
	task automatic check(input logic [14:0] seen, input logic [14:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// one immediate-mode conversion, checked at busy rise and by a read
	task automatic run(input logic [14:0] r, input logic [11:0] o, input logic s);
		@(posedge i_clk);
		raw <= r;
		sat <= s;
		h.conv_start(ok);
		check(ok, 1'b1);
		check(sh, 1'b1);
		h.conv_end(ok);
		check(ok, 1'b1);
		check(sh, 1'b0);
		check(q, exp_out(r, o, s));
		h.bus_rd(1'b0, oe, d);
		check(oe, 1'b1);
		check(d, exp_out(r, o, s));
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		i_nrst = 1'b0;
		mode_sel = 2'h1;
		sat = 1'b0;
		raw = 15'h0000;
		repeat (5) @(posedge i_clk);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_clk);
		// lowest raw corner: -1310 with offset -512 gives -1822
		h.bus_wr(12'he00, 1'b0);
		run(15'h7ae2, 12'he00, 1'b0);
		check(q, 15'h78e2);
		// offset table against every raw corner, both saturation settings
		foreach (offs[i]) begin
			h.bus_wr(offs[i], 1'b0);
			for (int s = 0; s < 2; s++)
				foreach (raws[j]) run(raws[j], offs[i], s[0]);
		end
		// write without select is ignored, read without select stays off
		h.bus_wr(12'h100, 1'b1);
		run(15'h0100, 12'h51e, 1'b0);
		h.bus_rd(1'b1, oe, d);
		check(oe, 1'b0);
		check(dut_oe, 1'b0);
		// random raw codes and legal offsets
		repeat (20) begin
			seed = xs(seed);
			off = 12'(seed[15:0] % 16'd2621 - 16'd1310);
			h.bus_wr(off, 1'b0);
			run(seed[30:16], off, seed[31]);
		end
		// deferred mode: result appears only at the next start
		@(posedge i_clk);
		mode_sel <= 2'h2;
		raw <= 15'h0123;
		repeat (3) @(posedge i_clk);
		held = q;
		h.conv_start(ok);
		h.conv_end(ok);
		check(q, held);
		@(posedge i_clk);
		raw <= 15'h0456;
		h.conv_start(ok);
		check(q, exp_out(15'h0123, off, sat));
		h.conv_end(ok);
		check(q, exp_out(15'h0123, off, sat));
		// reset after a finished conversion leaves busy high, clears the output register, flushes the buffer
		@(posedge i_clk);
		i_nrst <= 1'b0;
		repeat (5) @(posedge i_clk);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		check(busy_n, 1'b1);
		check(q, adc_port_pkg::RESULT_RESET);
		h.conv_start(ok);
		check(ok, 1'b1);
		h.conv_end(ok);
		check(ok, 1'b1);
		check(q, adc_port_pkg::RESULT_RESET);
		finish_test();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge i_clk);
		error_cnt++;
		finish_test();
	end
endmodule
